// ---- verilog/pif_pkg.sv ----
// Package of constants and types for the peripheral event flag register block.
// Summary of operation
// RULE_01 - Every event flag sets on its event whatever the enable or global enable state, so software may poll.
// RULE_02 - Software should clear a flag before enabling its interrupt and again after servicing it.
// RULE_03 - The parallel port access flag in bit 7 sets on an external port read or write and holds until written to zero.
// RULE_04 - On the small package variant the parallel port access flag is absent and reads as zero.
// RULE_05 - The converter done flag sets when a conversion completes and holds until software clears it.
// RULE_06 - The serial receive flag is read-only, high while the receive buffer holds data, cleared by reading it.
// RULE_07 - The serial transmit flag is read-only, high while the transmit buffer is empty, cleared by writing it.
// RULE_08 - The sync serial flag sets when a transfer completes and holds until software clears it.
// RULE_09 - In capture mode the capture/compare flag sets on each capture and holds until cleared.
// RULE_10 - In compare mode the capture/compare flag sets on a match; in pulse-width mode it is not driven.
// RULE_11 - The period match flag sets when timer b equals its period and holds until cleared.
// RULE_12 - The timer a overflow flag sets when timer a rolls over and holds until cleared.
// RULE_13 - A set event in the same cycle as a software clear of the same flag leaves the flag set.
package pif_pkg;

  // Byte offsets on the register bus.
  localparam logic [3:0] PIF_OFS_FLAGS  = 4'h0;
  localparam logic [3:0] PIF_OFS_ENABLE = 4'h4;
  localparam logic [3:0] PIF_OFS_STATUS = 4'h8;
  localparam logic [3:0] PIF_OFS_CTRL   = 4'hC;

  // Bit positions inside the flag register.
  localparam int PIF_BIT_PSP  = 7;
  localparam int PIF_BIT_ADC  = 6;
  localparam int PIF_BIT_RX   = 5;
  localparam int PIF_BIT_TX   = 4;
  localparam int PIF_BIT_SSP  = 3;
  localparam int PIF_BIT_CCP  = 2;
  localparam int PIF_BIT_PER  = 1;
  localparam int PIF_BIT_OVF  = 0;

  // Reset values.
  localparam logic [7:0] PIF_RST_FLAGS = 8'h00;
  localparam logic [7:0] PIF_RST_MASK  = 8'h00;
  localparam logic [1:0] PIF_RST_MODE  = 2'h0;

  // Software writable sticky bits of the flag register.
  localparam logic [7:0] PIF_STICKY_MASK = 8'hCF;

  typedef enum logic [1:0] {
    PIF_CCP_OFF,
    PIF_CCP_CAPTURE,
    PIF_CCP_COMPARE,
    PIF_CCP_PWM
  } pif_ccp_mode_e;

  // Event strobes from the peripherals, one cycle each.
  typedef struct packed {
    logic psp_access;
    logic adc_done;
    logic ssp_done;
    logic ccp_capture;
    logic ccp_match;
    logic period_match;
    logic timer_a_wrap;
  } pif_events_s;

  // Live levels from the serial buffers.
  typedef struct packed {
    logic rx_full;
    logic tx_empty;
  } pif_levels_s;

endpackage

// ---- verilog/pif_wb_slave.sv ----
// Classic Wishbone slave front end decoding four word registers.
module pif_wb_slave
  import pif_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic             ack_o,
  output logic             err_o,
  // Register side
  output logic             wr_o,
  output logic [3:0]       wadr_o,
  output logic [7:0]       wdat_o
);
  import pif_pkg::*;

  typedef struct packed {
    logic ack;
    logic err;
  } pif_wb_state_s;

  pif_wb_state_s st_q;
  pif_wb_state_s st_d;
  logic          req;
  logic          mapped;

  assign req    = cyc_i && stb_i && !st_q.ack && !st_q.err;
  assign mapped = adr_i[1:0] == 2'h0;
  assign wr_o   = req && mapped && we_i && sel_i[0];
  assign wadr_o = adr_i;
  assign wdat_o = dat_i[7:0];
  assign ack_o  = st_q.ack;
  assign err_o  = st_q.err;

  always_comb
  begin
    st_d.ack = req && mapped;
    st_d.err = req && !mapped;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end
endmodule

// ---- verilog/pif_sync.sv ----
// Two-stage synchroniser for a bundle of levels.
module pif_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } pif_sync_state_s;

  pif_sync_state_s st_q;
  pif_sync_state_s st_d;

  // A zero-width bundle has nothing to carry, so elaboration refuses it.
  if (WIDTH < 1)
  begin
    $error("WIDTH must be at least one.");
  end

  always_comb
  begin
    st_d.s1 = d_i;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign q_o = st_q.s2;
endmodule

// ---- verilog/pif_flags.sv ----
// Peripheral event flag register with interrupt status, mask and Wishbone access.
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
module pif_flags
  import pif_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [3:0]           adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic      [31:0]          dat_o,
  output logic                      ack_o,
  output logic                      err_o,
  // Peripheral events and serial buffer levels
  input  wire pif_pkg::pif_events_s events_i,
  input  wire pif_pkg::pif_levels_s levels_i,
  // Interrupt
  output logic                      irq_o
);
  import pif_pkg::*;

  typedef struct packed {
    logic [7:0]  flags;
    logic [7:0]  status;
    logic [7:0]  mask;
    logic [1:0]  mode;
    logic [31:0] rdata;
    logic        irq;
  } pif_state_s;

  pif_state_s  st_q;
  pif_state_s  st_d;
  logic        wr;
  logic [3:0]  wadr;
  logic [7:0]  wdat;
  logic        rd;
  pif_levels_s lv;
  logic [7:0]  set_vec;
  logic [7:0]  cur_flags;

  pif_wb_slave u_bus (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cyc_i  (cyc_i),
    .stb_i  (stb_i),
    .we_i   (we_i),
    .adr_i  (adr_i),
    .sel_i  (sel_i),
    .dat_i  (dat_i),
    .ack_o  (ack_o),
    .err_o  (err_o),
    .wr_o   (wr),
    .wadr_o (wadr),
    .wdat_o (wdat)
  );

  // Serial buffer levels come from another block that may sit on other timing; synchronising costs two cycles.
  pif_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (levels_i),
    .q_o   (lv)
  );

  assign rd = cyc_i && stb_i && !we_i && !ack_o && !err_o;

  always_comb
  begin
    set_vec = 8'h00;
    // RULE_01 set regardless of enables
    // RULE_03 parallel port access
    set_vec[PIF_BIT_PSP] = events_i.psp_access;
    // RULE_05 conversion complete
    set_vec[PIF_BIT_ADC] = events_i.adc_done;
    // RULE_08 transfer complete
    set_vec[PIF_BIT_SSP] = events_i.ssp_done;
    // RULE_09 capture event
    // RULE_10 compare match only
    set_vec[PIF_BIT_CCP] = (st_q.mode == PIF_CCP_CAPTURE && events_i.ccp_capture) ||
                           (st_q.mode == PIF_CCP_COMPARE && events_i.ccp_match);
    // RULE_11 period match
    set_vec[PIF_BIT_PER] = events_i.period_match;
    // RULE_12 overflow
    set_vec[PIF_BIT_OVF] = events_i.timer_a_wrap;
    // RULE_04 absent on small package
    if (SMALL_PACKAGE)
      set_vec[PIF_BIT_PSP] = 1'b0;
  end

  always_comb
  begin
    st_d = st_q;
    // RULE_13 set wins over clear
    if (wr && wadr == PIF_OFS_FLAGS)
      st_d.flags = (st_q.flags & (wdat | ~PIF_STICKY_MASK)) | set_vec;
    else
      st_d.flags = st_q.flags | set_vec;
    st_d.flags = st_d.flags & PIF_STICKY_MASK;
    // RULE_06 follows receive buffer
    st_d.flags[PIF_BIT_RX] = lv.rx_full;
    // RULE_07 follows transmit buffer
    st_d.flags[PIF_BIT_TX] = lv.tx_empty;
    cur_flags = st_d.flags;
    // Status catches every sticky event, even on a flag already set, so a repeat is not lost.
    // Level flags only report their rising edge; write one to clear, set wins.
    if (wr && wadr == PIF_OFS_STATUS)
      st_d.status = (st_q.status & ~wdat) | (cur_flags & ~st_q.flags) | (set_vec & PIF_STICKY_MASK);
    else
      st_d.status = st_q.status | (cur_flags & ~st_q.flags) | (set_vec & PIF_STICKY_MASK);
    if (wr && wadr == PIF_OFS_ENABLE)
      st_d.mask = wdat;
    if (wr && wadr == PIF_OFS_CTRL)
      st_d.mode = wdat[1:0];
    st_d.irq = |(st_d.status & st_d.mask);
    st_d.rdata = 32'h0000_0000;
    if (rd)
    begin
      case (adr_i)
        PIF_OFS_FLAGS:  st_d.rdata = {24'h000000, st_q.flags};
        PIF_OFS_ENABLE: st_d.rdata = {24'h000000, st_q.mask};
        PIF_OFS_STATUS: st_d.rdata = {24'h000000, st_q.status};
        PIF_OFS_CTRL:   st_d.rdata = {30'h0, st_q.mode};
        default:        st_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q        <= '0;
      st_q.flags  <= PIF_RST_FLAGS;
      st_q.mask   <= PIF_RST_MASK;
      st_q.mode   <= PIF_RST_MODE;
    end
    else
      st_q <= st_d;
  end

  assign dat_o = st_q.rdata;
  assign irq_o = st_q.irq;
endmodule

// ---- testbench/pif_checker.sv ----
// Port assertions for the peripheral event flag block.
module pif_checker
  import pif_pkg::*;
(
  // Clock and reset
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  // Wishbone
  input wire logic                 cyc_i,
  input wire logic                 stb_i,
  input wire logic                 we_i,
  input wire logic [3:0]           adr_i,
  input wire logic [31:0]          dat_o,
  input wire logic                 ack_o,
  input wire logic                 err_o,
  // Levels
  input wire pif_pkg::pif_levels_s levels_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (ack_o || err_o |=> !ack_o && !err_o) else $error("answer too long");
  ack_taken_a: assert property (cyc_i && stb_i && !ack_o && !err_o && adr_i[1:0] == 2'h0 |=> ack_o)
    else $error("no ack");
  err_unmapped_a: assert property (cyc_i && stb_i && !ack_o && !err_o && adr_i[1:0] != 2'h0 |=> err_o && !ack_o)
    else $error("no err");
  ack_cause_a: assert property (ack_o || err_o |-> $past(cyc_i && stb_i)) else $error("answer without request");
  err_cause_a: assert property (err_o |-> $past(adr_i[1:0]) != 2'h0) else $error("err on mapped offset");
  upper_zero_a: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0) else $error("upper bits set");
  ctrl_width_a: assert property (ack_o && !we_i && adr_i == PIF_OFS_CTRL |-> dat_o[7:2] == 6'h0)
    else $error("ctrl bits set");
  flag_levels_a: assert property ($stable(levels_i)[*5] ##0 (ack_o && !we_i && adr_i == PIF_OFS_FLAGS)
    |-> dat_o[5:4] == {levels_i.rx_full, levels_i.tx_empty}) else $error("level flags wrong");
endmodule

// ---- testbench/pif_periph_model.sv ----
// Peripheral event sources feeding the flag block.
module pif_periph_model
  import pif_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic [6:0]      fire_i,
  input  wire logic            rx_i,
  input  wire logic            tx_i,
  output pif_pkg::pif_events_s events_o,
  output pif_pkg::pif_levels_s levels_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign events_o = fire_i;
  always_ff @(posedge clk_i)
    levels_o <= {rx_i, tx_i};
endmodule

// ---- testbench/pif_flags_tb.sv ----
// Self-checking bench for the peripheral event flag block.
module pif_flags_tb
  import pif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, rx = 1'b0, tx = 1'b1;
  logic        ack, err, irq, got_err;
  logic [3:0]  adr = 4'h0, sel = 4'hF;
  logic [6:0]  fire = 7'h00;
  logic [31:0] dat = 32'h0, dout, rd, dout_small, rd_small;
  pif_events_s ev;
  pif_levels_s lv;
  int          n_errors = 0, compares = 0;
  pif_flags dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o(dout), .ack_o(ack), .err_o(err), .events_i(ev), .levels_i(lv), .irq_o(irq));
  pif_periph_model u_src (.clk_i(clk_i), .fire_i(fire), .rx_i(rx), .tx_i(tx), .events_o(ev), .levels_o(lv));
  // A small package copy sees the same traffic; only its flag readback is compared.
  pif_flags #(.SMALL_PACKAGE(1'b1)) dut_small (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dout_small), .ack_o(), .err_o(), .events_i(ev), .levels_i(lv),
    .irq_o());
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Waits for the answer however long it takes; only the watchdog ends a hung wait.
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= {24'h0, d};
    do
      @(posedge clk_i);
    while (!(ack || err));
    rd = dout;
    rd_small = dout_small;
    got_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdf(input logic [31:0] e);
    wb(1'b0, PIF_OFS_FLAGS, 8'h00);
    check("flags", rd, e);
    check("flags small", rd_small, e & 32'h0000_007F);
  endtask
  // Events are one-cycle pulses; the wait lets flag, status and irq settle.
  task automatic pulse(input logic [6:0] f);
    @(posedge clk_i);
    fire <= f;
    @(posedge clk_i);
    fire <= 7'h00;
    repeat (4) @(posedge clk_i);
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial forever #2.5 clk_i = ~clk_i;
  initial
  begin
    #50000;
    n_errors++;
    conclude();
  end
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, PIF_OFS_ENABLE, 8'h00);
    check("mask", rd, 32'h0);
    rdf(32'h10);
    wb(1'b1, PIF_OFS_CTRL, 8'h01);
    pulse(7'h7F);
    rdf(32'hDF);
    check("irq", irq, 1'b0);
    wb(1'b1, PIF_OFS_FLAGS, 8'hFF);
    rdf(32'hDF);
    wb(1'b1, PIF_OFS_FLAGS, 8'h00);
    rdf(32'h10);
    $display("test sticky done");
    for (int m = 0; m < 4; m++)
    begin
      wb(1'b1, PIF_OFS_CTRL, 8'(m));
      pulse(7'h08);
      rdf({29'h0, m == 1, 2'h0} | 32'h10);
      wb(1'b1, PIF_OFS_FLAGS, 8'h00);
      pulse(7'h04);
      rdf({29'h0, m == 2, 2'h0} | 32'h10);
      wb(1'b1, PIF_OFS_FLAGS, 8'h00);
    end
    $display("test capcomp done");
    rx <= 1'b1;
    tx <= 1'b0;
    repeat (5) @(posedge clk_i);
    wb(1'b1, PIF_OFS_FLAGS, 8'h00);
    rdf(32'h20);
    rx <= 1'b0;
    tx <= 1'b1;
    fork
      wb(1'b1, PIF_OFS_FLAGS, 8'h00);
      pulse(7'h01);
    join
    rdf(32'h11);
    $display("test levels done");
    wb(1'b1, PIF_OFS_STATUS, 8'hFF);
    wb(1'b1, PIF_OFS_ENABLE, 8'h02);
    check("irq", irq, 1'b0);
    pulse(7'h02);
    check("irq", irq, 1'b1);
    wb(1'b1, PIF_OFS_ENABLE, 8'h00);
    wb(1'b0, PIF_OFS_STATUS, 8'h00);
    check("status", rd, 32'h02);
    check("irq", irq, 1'b0);
    wb(1'b1, PIF_OFS_ENABLE, 8'h02);
    check("irq", irq, 1'b1);
    wb(1'b1, PIF_OFS_STATUS, 8'h02);
    wb(1'b0, PIF_OFS_STATUS, 8'h00);
    check("status", rd, 32'h0);
    check("irq", irq, 1'b0);
    $display("test irq done");
    wb(1'b1, 4'h6, 8'hFF);
    check("err", got_err, 1'b1);
    wb(1'b1, PIF_OFS_FLAGS, 8'h00, 4'h0);
    rdf(32'h13);
    $display("test refuse done");
    conclude();
  end
endmodule
bind pif_flags pif_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .levels_i(levels_i));
